// [dv/rtc_correction_chk_sva.sv]
// Port checker for the watch error correction block.
// Assumes one clock domain, mclk, with synchronous reset rst.
`timescale 1ns/1ps

module rtc_correction_chk
    import rtc_correction_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic count_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [SEC_W-1:0] seconds_value,
    input wire logic second_tick,
    input wire logic minute_tick
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == '0)
        else $error("read data not zero outside a read answer");
    a_unmapped_reads_zero: assert property (rd_stb && addr > 3'h5 |=> rdata == '0)
        else $error("unmapped read returned nonzero");
    a_sec_in_range: assert property (seconds_value <= SEC_LAST)
        else $error("seconds counter out of range");
    a_tick_step: assert property (second_tick |-> seconds_value ==
        (($past(seconds_value) == SEC_LAST) ? SEC_FIRST : $past(seconds_value) + 6'h01))
        else $error("seconds did not advance by one on a carry");
    a_tick_cause: assert property (second_tick |-> $past(count_en))
        else $error("carry without a count enable");
    a_tick_spacing: assert property (second_tick |=> !second_tick [*8])
        else $error("seconds carries too close together");
    a_minute_wrap: assert property (second_tick && seconds_value == SEC_FIRST |-> minute_tick)
        else $error("minute tick missing on wrap");
    a_minute_only_wrap: assert property (minute_tick |-> second_tick && seconds_value == SEC_FIRST)
        else $error("minute tick without wrap");
    a_sec_hold: assert property (!$past(count_en) && !$past(wr_stb) |-> $stable(seconds_value))
        else $error("seconds moved without cause");
endmodule : rtc_correction_chk

bind rtc_watch_error_correction rtc_correction_chk chk (.mclk(mclk), .rst(rst),
    .count_en(count_en), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .seconds_value(seconds_value), .second_tick(second_tick), .minute_tick(minute_tick));

// [dv/rtc_watch_error_correction_tb_top.sv]
// Self-checking bench for the watch error correction block.
// Assumes the register port answers reads one cycle later, never stalling.
`timescale 1ns/1ps

module rtc_watch_error_correction_tb_top
    import rtc_correction_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic count_en = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [SEC_W-1:0] seconds_value;
    logic second_tick;
    logic minute_tick;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] corr_tab [11] = '{8'h00, 8'h01, 8'h41, 8'h02, 8'h42, 8'h15, 8'h55, 8'h3f,
        8'h7f, 8'hc2, 8'hbf};
    logic [5:0] sec_tab [6] = '{6'h00, 6'h14, 6'h28, 6'h01, 6'h3b, 6'h15};

    always #2.5 mclk = ~mclk;

    rtc_watch_error_correction dut (.mclk(mclk), .rst(rst), .count_en(count_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .seconds_value(seconds_value), .second_tick(second_tick), .minute_tick(minute_tick));

    task automatic check(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got,
        input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        check(exp, rdata, what);
        @(posedge mclk);
    endtask : rd

    // Last sub-second value of a second, worked out from the correction setting
    function automatic logic [DATA_W-1:0] last_of(input logic [7:0] c, input logic [5:0] s);
        logic [15:0] m;
        m = {10'h000, c[5:0]};
        if (m <= 16'h0001 || (c[7] ? s != 6'h00 : !(s == 6'h00 || s == 6'h14 || s == 6'h28)))
            return 16'h7fff;
        if (c[6])
            return 16'h7fff - ((m ^ 16'h003f) + 16'h0001) * 16'h0002;
        return 16'h7fff + (m - 16'h0001) * 16'h0002;
    endfunction : last_of

    // Counts enabled cycles until the carry shows. The tick is seen just after
    // its edge, so count_en stays up one more edge: the next second holds 1.
    task automatic run_second(input int exp_n, input logic [5:0] exp_sec, input logic exp_min);
        int n;
        n = 0;
        count_en <= 1'b1;
        while (second_tick !== 1'b1 && n < 40000)
        begin
            @(posedge mclk);
            n++;
            #1;
        end
        check(exp_n[15:0], n[15:0], "cycles in second");
        check({10'h000, exp_sec}, {10'h000, seconds_value}, "seconds after carry");
        check({15'h0000, exp_min}, {15'h0000, minute_tick}, "minute tick");
        @(posedge mclk);
        count_en <= 1'b0;
        @(posedge mclk);
    endtask : run_second

    task automatic results();
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        #400000;
        err_total++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(WATCH_CORRECTION_OFS, 16'h0000, "correction after reset");
        rd(SECOND_LAST_OFS, 16'h7fff, "length after reset");
        wr(CONTROL_OFS, 16'h0001);
        @(posedge mclk);
        foreach (corr_tab[i])
            foreach (sec_tab[j])
            begin
                wr(WATCH_CORRECTION_OFS, {8'h00, corr_tab[i]});
                wr(SECONDS_COUNTER_OFS, {10'h000, sec_tab[j]});
                rd(WATCH_CORRECTION_OFS, {8'h00, corr_tab[i]}, "correction readback");
                rd(SECOND_LAST_OFS, last_of(corr_tab[i], sec_tab[j]), "second length");
            end
        wr(WATCH_CORRECTION_OFS, 16'h00c2);
        wr(SECONDS_COUNTER_OFS, 16'h0000);
        rd(SECOND_LAST_OFS, 16'h7f83, "length at 60-second point");
        wr(WATCH_CORRECTION_OFS, 16'h0002);
        rd(SECOND_LAST_OFS, 16'h7f83, "length held after new setting");
        rd(STATUS_OFS, 16'h0003, "status of shortened second");
        wr(WATCH_CORRECTION_OFS, 16'h0042);
        wr(3'h7, 16'h00ff);
        rd(3'h7, 16'h0000, "unmapped read");
        wr(SECOND_LAST_OFS, 16'h1234);
        rd(SECOND_LAST_OFS, 16'h7f83, "read-only length");
        wr(SECONDS_COUNTER_OFS, 16'h003b);
        run_second(32768, 6'h00, 1'b1);
        rd(SECOND_LAST_OFS, 16'h7f83, "length at second zero");
        rd(SUBSECOND_COUNTER_OFS, 16'h0001, "count after carry");
        wr(SECONDS_COUNTER_OFS, 16'h0000);
        run_second(32644, 6'h01, 1'b0);
        rd(SECOND_LAST_OFS, 16'h7fff, "length at second one");
        results();
    end
endmodule : rtc_watch_error_correction_tb_top

// [rtl/rtc_watch_error_correction.sv]
// Sub-second divider and seconds counter of a real-time counter, with
// watch error correction applied at chosen seconds.
// Assumes count_en is a one-cycle pulse per count-clock period, synchronous
// to mclk, and a register master that never issues read and write together.
// Read data answer one cycle after the read strobe; the master never waits.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps

module rtc_watch_error_correction
    import rtc_correction_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic count_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    output logic [SEC_W-1:0] seconds_value,
    output logic second_tick,
    output logic minute_tick
);

    logic [CORR_W-1:0] watch_correction_reg;
    logic run_enable_reg;
    run_state_t state_reg;
    run_state_t state_next;
    logic [SUB_W-1:0] subsecond_cycle_counter_reg;
    logic [SEC_W-1:0] seconds_counter_reg;
    logic [SUB_W-1:0] second_last_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic second_tick_reg;
    logic minute_tick_reg;

    logic seconds_in_range;
    logic seconds_write;
    logic correction_write;
    logic control_write;
    logic start_second;
    logic carry;
    logic carry_taken;
    logic second_corrected;
    logic second_lengthened;
    logic [SEC_W-1:0] seconds_after;
    logic [DATA_W-1:0] read_mux;

    // Decides whether the second that starts with counter value sec is a
    // correction point; every other second keeps the nominal length.
    function automatic logic correction_point
    (
        input logic [SEC_W-1:0] sec,
        input logic [CORR_W-1:0] corr
    );
        if (corr[CORR_INTERVAL_BIT])
        begin
            correction_point = sec == SEC_POINT_A;
        end
        else
        begin
            correction_point = sec == SEC_POINT_A || sec == SEC_POINT_B
                || sec == SEC_POINT_C;
        end
    endfunction : correction_point

    // Last sub-second value of the second that starts with counter value sec.
    // Amounts are always even, so the longest second ends at 807BH and the
    // shortest at 7F83H; both fit the 16-bit counter.
    function automatic logic [SUB_W-1:0] second_last
    (
        input logic [SEC_W-1:0] sec,
        input logic [CORR_W-1:0] corr
    );
        logic point;
        logic [CORR_MAG_W-1:0] mag;
        logic [CORR_MAG_W:0] shorten;
        logic [SUB_W-1:0] extra;
        logic [SUB_W-1:0] removed;
        point = correction_point(sec, corr);
        mag = corr[CORR_MAG_LSB +: CORR_MAG_W];
        shorten = {1'b0, ~mag} + 7'h01;
        extra = {9'h000, mag - 6'h01, 1'b0};
        removed = {8'h00, shorten, 1'b0};
        if (!point || mag <= MAG_NO_CORR_MAX)
        begin
            second_last = SUB_NOMINAL_LAST;
        end
        else if (!corr[CORR_DIRECTION_BIT])
        begin
            // Lengthened seconds run past 7FFFH before the carry
            second_last = SUB_NOMINAL_LAST + extra;
        end
        else
        begin
            second_last = SUB_NOMINAL_LAST - removed;
        end
    endfunction : second_last

    // Seconds values above 59 are dropped whole, so the counter never has to
    // recover from an illegal value.
    assign seconds_in_range = wdata[SEC_W-1:0] <= SEC_LAST && wdata[DATA_W-1:SEC_W] == '0;
    assign seconds_write = wr_stb && addr == SECONDS_COUNTER_OFS && seconds_in_range;
    assign correction_write = wr_stb && addr == WATCH_CORRECTION_OFS;
    assign control_write = wr_stb && addr == CONTROL_OFS;
    assign start_second = state_reg == ST_STOPPED && run_enable_reg;
    // The carry compares against the length latched at the start of the
    // second, never against the live correction register.
    assign carry = state_reg == ST_RUNNING && count_en
        && subsecond_cycle_counter_reg == second_last_reg;
    // A seconds write in the carry cycle wins; the lost carry shows no tick.
    assign carry_taken = carry && !seconds_write;
    // Status follows the length in force for the second being counted
    assign second_corrected = second_last_reg != SUB_NOMINAL_LAST;
    assign second_lengthened = second_last_reg > SUB_NOMINAL_LAST;
    assign seconds_after = (seconds_counter_reg == SEC_LAST)
        ? SEC_FIRST : seconds_counter_reg + 6'h01;

    // Correction setting; it only steers the count when a second begins
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            watch_correction_reg <= WATCH_CORRECTION_RESET;
        end
        else if (correction_write)
        begin
            watch_correction_reg <= wdata[CORR_W-1:0];
        end
    end

    // Run control; stopping holds both counters where they are, while a
    // restart drops the partial second and begins a fresh one.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            run_enable_reg <= CONTROL_RUN_RESET;
        end
        else if (control_write)
        begin
            run_enable_reg <= wdata[CONTROL_RUN_BIT];
        end
    end

    // Start takes one cycle so that the first length is chosen before counting
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STOPPED:
            begin
                if (run_enable_reg)
                begin
                    state_next = ST_RUNNING;
                end
            end
            ST_RUNNING:
            begin
                if (!run_enable_reg)
                begin
                    state_next = ST_STOPPED;
                end
            end
            default:
            begin
                state_next = ST_STOPPED;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= ST_STOPPED;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // A restart or a seconds write begins a fresh second at 0000H, so the
    // length chosen for it always matches the seconds value it counts.
    // Count enables are ignored while stopped.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            subsecond_cycle_counter_reg <= SUB_FIRST;
        end
        else if (seconds_write || start_second || carry)
        begin
            subsecond_cycle_counter_reg <= SUB_FIRST;
        end
        else if (state_reg == ST_RUNNING && count_en)
        begin
            subsecond_cycle_counter_reg <= subsecond_cycle_counter_reg + 16'h0001;
        end
    end

    // Binary count 0 to 59; the carry out of 59 is the minute tick
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            seconds_counter_reg <= SEC_FIRST;
        end
        else if (seconds_write)
        begin
            seconds_counter_reg <= wdata[SEC_W-1:0];
        end
        else if (carry)
        begin
            seconds_counter_reg <= seconds_after;
        end
    end

    // Length is fixed once per second from the register as it stands then
    // A setting written mid-second is picked up at the next carry, seconds write or restart.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            second_last_reg <= SUB_NOMINAL_LAST;
        end
        else if (seconds_write)
        begin
            second_last_reg <= second_last(wdata[SEC_W-1:0], watch_correction_reg);
        end
        else if (start_second)
        begin
            second_last_reg <= second_last(seconds_counter_reg, watch_correction_reg);
        end
        else if (carry)
        begin
            second_last_reg <= second_last(seconds_after, watch_correction_reg);
        end
    end

    // Tick pulses stand for one cycle, together with the new seconds value
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            second_tick_reg <= 1'b0;
        end
        else
        begin
            second_tick_reg <= carry_taken;
        end
    end

    // The minute tick marks the wrap from 59 back to 0
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            minute_tick_reg <= 1'b0;
        end
        else
        begin
            minute_tick_reg <= carry_taken && seconds_counter_reg == SEC_LAST;
        end
    end

    // Upper bits of the narrow registers read as zero
    always_comb
    begin
        read_mux = '0;
        unique case (addr)
            WATCH_CORRECTION_OFS:
            begin
                read_mux = {8'h00, watch_correction_reg};
            end
            SECONDS_COUNTER_OFS:
            begin
                read_mux = {10'h000, seconds_counter_reg};
            end
            SUBSECOND_COUNTER_OFS:
            begin
                read_mux = subsecond_cycle_counter_reg;
            end
            CONTROL_OFS:
            begin
                read_mux[CONTROL_RUN_BIT] = run_enable_reg;
            end
            SECOND_LAST_OFS:
            begin
                read_mux = second_last_reg;
            end
            STATUS_OFS:
            begin
                read_mux[STATUS_RUNNING_BIT] = state_reg == ST_RUNNING;
                read_mux[STATUS_CORRECTED_BIT] = second_corrected;
                read_mux[STATUS_LENGTHENED_BIT] = second_lengthened;
            end
            default:
            begin
                read_mux = '0;
            end
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata_reg <= '0;
        end
        else if (rd_stb)
        begin
            rdata_reg <= read_mux;
        end
        else
        begin
            rdata_reg <= '0;
        end
    end

    // Every output is a flip-flop; nothing combinational reaches a pin
    assign rdata = rdata_reg;
    assign seconds_value = seconds_counter_reg;
    assign second_tick = second_tick_reg;
    assign minute_tick = minute_tick_reg;

endmodule : rtc_watch_error_correction

// [shared/rtc_correction_pkg.sv]
// Constants for the watch error correction block: register map, field
// layout of the correction register, counter limits and run states.
// Assumes a count-clock enable of nominally 32.768 kHz from outside.
package rtc_correction_pkg;

    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] WATCH_CORRECTION_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] SECONDS_COUNTER_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] SUBSECOND_COUNTER_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] SECOND_LAST_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h5;

    // Correction register layout
    localparam int CORR_W = 8;
    localparam int CORR_INTERVAL_BIT = 7;
    localparam int CORR_DIRECTION_BIT = 6;
    localparam int CORR_MAG_LSB = 0;
    localparam int CORR_MAG_W = 6;
    localparam logic [CORR_W-1:0] WATCH_CORRECTION_RESET = 8'h00;
    localparam logic [CORR_MAG_W-1:0] MAG_NO_CORR_MAX = 6'h01;

    // Control and status layout
    localparam int CONTROL_RUN_BIT = 0;
    localparam logic CONTROL_RUN_RESET = 1'b0;
    localparam int STATUS_RUNNING_BIT = 0;
    localparam int STATUS_CORRECTED_BIT = 1;
    localparam int STATUS_LENGTHENED_BIT = 2;

    // Counter limits
    localparam int SUB_W = 16;
    localparam logic [SUB_W-1:0] SUB_FIRST = 16'h0000;
    localparam logic [SUB_W-1:0] SUB_NOMINAL_LAST = 16'h7fff;
    localparam int SEC_W = 6;
    localparam logic [SEC_W-1:0] SEC_FIRST = 6'h00;
    localparam logic [SEC_W-1:0] SEC_LAST = 6'h3b;
    localparam logic [SEC_W-1:0] SEC_POINT_A = 6'h00;
    localparam logic [SEC_W-1:0] SEC_POINT_B = 6'h14;
    localparam logic [SEC_W-1:0] SEC_POINT_C = 6'h28;

    typedef enum logic [1:0]
    {
        ST_STOPPED = 2'b01,
        ST_RUNNING = 2'b10
    } run_state_t;

endpackage : rtc_correction_pkg
